// ---- ofa_core.sv ----
`timescale 1ns/1ns
`default_nettype none
module ofa_core
    import ofa_pkg::*;
(
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // status sources
    input wire logic i_alarm_one,
    input wire logic i_alarm_two,
    input wire logic i_alarm_three,
    input wire logic i_alarm_four,
    input wire logic i_heater_break_alarm,
    input wire logic i_heater_short_alarm,
    input wire logic i_input_error,
    input wire logic i_remote_setpoint_error,
    input wire logic i_program_end,
    input wire logic i_run,
    input wire logic [7:0] i_work_bits,
    // analogue values
    input wire logic [15:0] i_heat_mv,
    input wire logic [15:0] i_cool_mv,
    input wire logic [15:0] i_pv,
    input wire logic [15:0] i_ramp_sp,
    input wire logic [15:0] i_sp,
    // outputs
    output logic [1:0] o_ctrl_on,
    output logic [15:0] o_ctrl1_val,
    output logic [15:0] o_ctrl2_val,
    output logic [3:0] o_aux_on,
    output logic o_irq
);
    logic [4:0] ctrl_q [2];
    logic [4:0] aux_q [4];
    logic [7:0] combined_alarm_mask_q;
    logic [9:0] cfg_q;
    logic [5:0] irq_stat_q;
    logic [5:0] irq_mask_q;
    logic [1:0] ctrl_on_q;
    logic [3:0] aux_on_q;
    logic [15:0] ctrl_val_q [2];
    logic [5:0] prev_ev_q;

    wire logic heatcool = cfg_q[OFA_CFG_HEATCOOL];
    wire logic prg_on = cfg_q[OFA_CFG_PRG_ON];
    wire logic logic_on = cfg_q[OFA_CFG_LOGIC_ON];
    wire logic two_ctrl = cfg_q[OFA_CFG_TWO_CTRL];
    wire logic variant_b = cfg_q[OFA_CFG_VARIANT_B];
    wire logic [1:0] aux_cnt = cfg_q[OFA_CFG_AUX_CNT +: 2];
    wire logic [7:0] alm_src = {i_remote_setpoint_error, i_input_error, i_heater_short_alarm,
                                i_heater_break_alarm, i_alarm_four, i_alarm_three,
                                i_alarm_two, i_alarm_one};
    wire logic combined_alarm = |(alm_src & combined_alarm_mask_q);
    wire logic heater_alarm = i_heater_break_alarm | i_heater_short_alarm;
    // bit source vector indexed by function code
    wire logic [15:0] bit_src = {1'b0, combined_alarm, i_run, i_program_end,
                                 i_remote_setpoint_error, i_input_error, i_heater_short_alarm,
                                 i_heater_break_alarm, heater_alarm, alm_src[3:0], 3'b000};

    // cooling destination on single-control parts
    wire logic [1:0] cool_aux_idx = (variant_b && aux_cnt == 2'd3) ? 2'd3 : 2'd1;
    wire logic cool_aux_en = heatcool && !two_ctrl && (aux_cnt != 2'd0);
    wire logic [4:0] ctrl2_eff = (heatcool && two_ctrl) ? OFA_FN_COOL : ctrl_q[1];

    // apb decode
    wire logic acc = i_psel && i_penable;
    wire logic wr = acc && i_pwrite;
    // widx drops the top address bits, so writes through it must also be mapped
    wire logic [3:0] widx = 4'(i_paddr[7:2]);
    wire logic mapped = (i_paddr[1:0] == 2'b00) && (i_paddr <= OFA_REG_IRQ_MASK);
    wire logic [7:0] ev_now = {2'b00, i_input_error, i_remote_setpoint_error,
                               combined_alarm, i_program_end && prg_on, i_alarm_one, i_run};
    wire logic [5:0] ev_rise = ev_now[5:0] & ~prev_ev_q;
    wire logic [5:0] w1c = (wr && i_paddr == OFA_REG_IRQ_STAT) ? i_pwdata[5:0] : 6'h00;

    assign o_pready = 1'b1;
    assign o_pslverr = acc && !mapped;
    assign o_irq = |(irq_stat_q & irq_mask_q);
    assign o_ctrl_on = ctrl_on_q;
    assign o_aux_on = aux_on_q;
    assign o_ctrl1_val = ctrl_val_q[0];
    assign o_ctrl2_val = ctrl_val_q[1];

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (i_paddr)
            OFA_REG_CTRL1: rd_mux[4:0] = ctrl_q[0];
            OFA_REG_CTRL2: rd_mux[4:0] = ctrl2_eff;
            OFA_REG_AUX1: rd_mux[4:0] = aux_q[0];
            OFA_REG_AUX2: rd_mux[4:0] = aux_q[1];
            OFA_REG_AUX3: rd_mux[4:0] = aux_q[2];
            OFA_REG_AUX4: rd_mux[4:0] = aux_q[3];
            OFA_REG_MASK_SUM: rd_mux[7:0] = combined_alarm_mask_q;
            OFA_REG_CFG: rd_mux[9:0] = cfg_q;
            OFA_REG_OUT: rd_mux[5:0] = {aux_on_q, ctrl_on_q};
            OFA_REG_IRQ_STAT: rd_mux[5:0] = irq_stat_q;
            OFA_REG_IRQ_MASK: rd_mux[5:0] = irq_mask_q;
            default: rd_mux = 32'h0000_0000;
        endcase
    end
    assign o_prdata = rd_mux;

    // function-code writes keep the low five data bits; aux codes above 22 clip to disabled by the selector
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            ctrl_q[0] <= OFA_CTRL1_RST;
            ctrl_q[1] <= OFA_CTRL2_RST;
            combined_alarm_mask_q <= OFA_MASK_RST;
            cfg_q <= OFA_CFG_RST;
            irq_mask_q <= 6'h00;
        end else if (wr) begin
            if (i_paddr == OFA_REG_CTRL1) ctrl_q[0] <= i_pwdata[4:0];
            if (i_paddr == OFA_REG_CTRL2) ctrl_q[1] <= i_pwdata[4:0];
            if (i_paddr == OFA_REG_MASK_SUM) combined_alarm_mask_q <= i_pwdata[7:0];
            if (i_paddr == OFA_REG_CFG) cfg_q <= i_pwdata[9:0];
            if (i_paddr == OFA_REG_IRQ_MASK) irq_mask_q <= i_pwdata[5:0];
        end
    end

    // aux one's default depends on the hb/hs strap held in cfg at reset
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_aux_reg
            always_ff @(posedge i_mclk) begin
                if (i_sys_rst) begin
                    if (g == 0 && OFA_CFG_RST[OFA_CFG_HB_HS]) begin
                        aux_q[g] <= OFA_FN_HTR_ALM;
                    end else begin
                        aux_q[g] <= 5'(OFA_FN_ALARM_ONE_SEL + g);
                    end
                end else if (wr && mapped && widx == 4'(2 + g)) begin
                    aux_q[g] <= i_pwdata[4:0];
                end
            end
        end
    endgenerate
    // set wins over a simultaneous write-one clear
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            irq_stat_q <= 6'h00;
            prev_ev_q <= 6'h00;
        end else begin
            irq_stat_q <= (irq_stat_q & ~w1c) | ev_rise;
            prev_ev_q <= ev_now[5:0];
        end
    end

    // output selection per output
    logic [1:0] ctrl_on_d;
    logic [15:0] ctrl_val_d [2];
    logic [3:0] aux_on_d;
    logic [4:0] ctrl_fn [2];
    assign ctrl_fn[0] = ctrl_q[0];
    assign ctrl_fn[1] = ctrl2_eff;
    generate
        for (g = 0; g < 2; g++) begin : g_ctrl
            ofa_out_sel u_sel (
                .i_fn(ctrl_fn[g]),
                .i_allow_bits(cfg_q[OFA_CFG_CTRL1_SW + g]),
                .i_allow_tr(g == 0 || two_ctrl),
                .i_logic_on(logic_on),
                .i_heatcool(heatcool),
                .i_prg_on(prg_on),
                .i_bit_src(bit_src),
                .i_work(i_work_bits),
                .i_heat_mv(i_heat_mv),
                .i_cool_mv(i_cool_mv),
                .i_pv(i_pv),
                .i_ramp_sp(i_ramp_sp),
                .i_sp(i_sp),
                .o_on(ctrl_on_d[g]),
                .o_val(ctrl_val_d[g])
            );
        end
        for (g = 0; g < 4; g++) begin : g_aux
            wire logic [4:0] fn_raw = aux_q[g] > OFA_FN_WORK8 ? OFA_FN_DISABLED : aux_q[g];
            wire logic take_cool = cool_aux_en && (2'(g) == cool_aux_idx) &&
                                   (2'(g) <= aux_cnt);
            wire logic [4:0] fn_eff = take_cool ? OFA_FN_COOL : fn_raw;
            ofa_out_sel u_sel (
                .i_fn(fn_eff),
                .i_allow_bits(1'b1),
                .i_allow_tr(1'b0),
                .i_logic_on(logic_on),
                .i_heatcool(heatcool),
                .i_prg_on(prg_on),
                .i_bit_src(bit_src),
                .i_work(i_work_bits),
                .i_heat_mv(i_heat_mv),
                .i_cool_mv(i_cool_mv),
                .i_pv(i_pv),
                .i_ramp_sp(i_ramp_sp),
                .i_sp(i_sp),
                .o_on(aux_on_d[g]),
                .o_val()
            );
        end
    endgenerate

    // registered every clock: one cycle from source or assignment change
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            ctrl_on_q <= 2'b00;
            aux_on_q <= 4'h0;
            ctrl_val_q[0] <= 16'h0000;
            ctrl_val_q[1] <= 16'h0000;
        end else begin
            ctrl_on_q <= ctrl_on_d;
            aux_on_q <= aux_on_d;
            ctrl_val_q[0] <= ctrl_val_d[0];
            ctrl_val_q[1] <= ctrl_val_d[1];
        end
    end

    a_comb_alarm: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (aux_q[0] == OFA_FN_COMB_ALM && !cool_aux_en) |=> (aux_on_q[0] == $past(combined_alarm)))
        else $error("aux one does not follow combined alarm");
    a_mask_reset: assert property (@(posedge i_mclk)
        $past(i_sys_rst) |-> combined_alarm_mask_q == 8'h31)
        else $error("mask sum not 49 after reset");
    a_ctrl_reset: assert property (@(posedge i_mclk)
        $past(i_sys_rst) |-> (ctrl_q[0] == OFA_FN_HEAT && ctrl_q[1] == OFA_FN_DISABLED))
        else $error("control assignment reset wrong");
    a_heatcool_two: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (heatcool && two_ctrl) |=> ctrl_val_q[1] == $past(i_cool_mv))
        else $error("control two not cooling");
    a_cool_zero: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (ctrl_q[0] == OFA_FN_COOL && !heatcool) |=> ctrl_val_q[0] == 16'h0000)
        else $error("cooling not zero under standard control");
    a_bits_gated: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (ctrl_q[0] == OFA_FN_RUN && !cfg_q[OFA_CFG_CTRL1_SW]) |=> !ctrl_on_q[0])
        else $error("bit function on linear output");
    a_prg_off: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (!prg_on && ctrl_q[0] == OFA_FN_PRG_END) |=> !ctrl_on_q[0])
        else $error("program end active while programs off");
    a_work_hidden: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (!logic_on && ctrl_q[0] == OFA_FN_WORK1) |=> !ctrl_on_q[0])
        else $error("work bit active without logic operation");
    a_aux_reset: assert property (@(posedge i_mclk)
        $past(i_sys_rst) |-> (aux_q[1] == OFA_FN_ALARM_TWO_SEL && aux_q[2] == OFA_FN_ALARM_THREE_SEL &&
        aux_q[3] == OFA_FN_ALARM_FOUR_SEL &&
        aux_q[0] == (OFA_CFG_RST[OFA_CFG_HB_HS] ? OFA_FN_HTR_ALM : OFA_FN_ALARM_ONE_SEL)))
        else $error("aux default wrong");
    a_run_follow: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (ctrl_q[0] == OFA_FN_RUN && cfg_q[OFA_CFG_CTRL1_SW]) |=> ctrl_on_q[0] == $past(i_run))
        else $error("run not passed in one cycle");

    // single control output with heating and cooling: one aux output takes cooling unless aux_cnt is zero
    sequence s_single_heatcool;
        heatcool && !two_ctrl;
    endsequence

    a_cool_aux_four: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        s_single_heatcool ##0 (variant_b && aux_cnt == 2'd3) |=>
        aux_on_q[3] == $past(|i_cool_mv))
        else $error("aux four not cooling");
    a_cool_aux_two: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        s_single_heatcool ##0 ((!variant_b || aux_cnt == 2'd1) && aux_cnt != 2'd0) |=>
        aux_on_q[1] == $past(|i_cool_mv))
        else $error("aux two not cooling");
    a_cool_aux_none: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        s_single_heatcool ##0 (aux_cnt == 2'd0 && aux_q[0] == OFA_FN_DISABLED) |=>
        !aux_on_q[0])
        else $error("lone aux output took cooling");
    a_aux_run: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (aux_q[2] == OFA_FN_RUN) |=> aux_on_q[2] == $past(i_run))
        else $error("aux three does not follow run");
    // an event in the same cycle as a write-one clear must not be lost
    a_irq_set_wins: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (ev_rise != 6'h00) |=> (irq_stat_q & $past(ev_rise)) == $past(ev_rise))
        else $error("event lost to a clear");
endmodule
`default_nettype wire

// ---- ofa_pkg.sv ----
package ofa_pkg;

    // function codes for output assignment
    typedef enum logic [4:0] {
        OFA_FN_DISABLED  = 5'h00,
        OFA_FN_HEAT      = 5'h01,
        OFA_FN_COOL      = 5'h02,
        OFA_FN_ALARM_ONE_SEL      = 5'h03,
        OFA_FN_ALARM_TWO_SEL      = 5'h04,
        OFA_FN_ALARM_THREE_SEL      = 5'h05,
        OFA_FN_ALARM_FOUR_SEL      = 5'h06,
        OFA_FN_HTR_ALM   = 5'h07,
        OFA_FN_HTR_BRK   = 5'h08,
        OFA_FN_HTR_SHORT = 5'h09,
        OFA_FN_IN_ERR    = 5'h0A,
        OFA_FN_RSP_ERR   = 5'h0B,
        OFA_FN_PRG_END   = 5'h0C,
        OFA_FN_RUN       = 5'h0D,
        OFA_FN_COMB_ALM  = 5'h0E,
        OFA_FN_WORK1     = 5'h0F,
        OFA_FN_WORK8     = 5'h16,
        OFA_FN_TR_COOL   = 5'h17,
        OFA_FN_TR_HEAT   = 5'h18,
        OFA_FN_TR_PV     = 5'h19,
        OFA_FN_TR_RSP    = 5'h1A,
        OFA_FN_TR_SP     = 5'h1B
    } ofa_fn_t;

    // apb register byte offsets
    localparam logic [7:0] OFA_REG_CTRL1 = 8'h00;
    localparam logic [7:0] OFA_REG_CTRL2 = 8'h04;
    localparam logic [7:0] OFA_REG_AUX1 = 8'h08;
    localparam logic [7:0] OFA_REG_AUX2 = 8'h0C;
    localparam logic [7:0] OFA_REG_AUX3 = 8'h10;
    localparam logic [7:0] OFA_REG_AUX4 = 8'h14;
    localparam logic [7:0] OFA_REG_MASK_SUM = 8'h18;
    localparam logic [7:0] OFA_REG_CFG = 8'h1C;
    localparam logic [7:0] OFA_REG_OUT = 8'h20;
    localparam logic [7:0] OFA_REG_IRQ_STAT = 8'h24;
    localparam logic [7:0] OFA_REG_IRQ_MASK = 8'h28;

    // cfg register bit positions
    localparam int OFA_CFG_HEATCOOL = 0;
    localparam int OFA_CFG_PRG_ON = 1;
    localparam int OFA_CFG_LOGIC_ON = 2;
    localparam int OFA_CFG_HB_HS = 3;
    localparam int OFA_CFG_CTRL1_SW = 4;
    localparam int OFA_CFG_CTRL2_SW = 5;
    localparam int OFA_CFG_TWO_CTRL = 6;
    localparam int OFA_CFG_VARIANT_B = 7;
    localparam int OFA_CFG_AUX_CNT = 8;

    // reset values
    localparam logic [7:0] OFA_MASK_RST = 8'h31;
    localparam logic [9:0] OFA_CFG_RST = 10'h3F0;
    localparam logic [4:0] OFA_CTRL1_RST = 5'h01;
    localparam logic [4:0] OFA_CTRL2_RST = 5'h00;

    // integrated alarm source weights, by bit
    localparam int OFA_W_ALARM_ONE_SEL = 0;
    localparam int OFA_W_HBRK = 4;
    localparam int OFA_W_HSHT = 5;
    localparam int OFA_W_INERR = 6;
    localparam int OFA_W_RSPERR = 7;

endpackage

// ---- ofa_out_sel.sv ----
`timescale 1ns/1ns
`default_nettype none
module ofa_out_sel
    import ofa_pkg::*;
(
    // selection
    input wire logic [4:0] i_fn,
    input wire logic i_allow_bits,
    input wire logic i_allow_tr,
    input wire logic i_logic_on,
    input wire logic i_heatcool,
    input wire logic i_prg_on,
    // sources
    input wire logic [15:0] i_bit_src,
    input wire logic [7:0] i_work,
    input wire logic [15:0] i_heat_mv,
    input wire logic [15:0] i_cool_mv,
    input wire logic [15:0] i_pv,
    input wire logic [15:0] i_ramp_sp,
    input wire logic [15:0] i_sp,
    // result
    output logic o_on,
    output logic [15:0] o_val
);
    wire logic is_work = (i_fn >= OFA_FN_WORK1) && (i_fn <= OFA_FN_WORK8);
    wire logic is_bitfn = (i_fn >= OFA_FN_ALARM_ONE_SEL) && (i_fn <= OFA_FN_WORK8);
    wire logic is_tr = (i_fn >= OFA_FN_TR_COOL) && (i_fn <= OFA_FN_TR_SP);
    wire logic [2:0] work_idx = 3'(i_fn - OFA_FN_WORK1);
    wire logic [3:0] bit_idx = 4'(i_fn);
    // bit functions refused on linear outputs; work bits need logic operation
    wire logic bit_ok = i_allow_bits && !(is_work && !i_logic_on);
    wire logic bit_val = is_work ? i_work[work_idx] :
                         (i_fn == OFA_FN_PRG_END) ? (i_bit_src[bit_idx] && i_prg_on) :
                         i_bit_src[bit_idx];
    // cooling under heating-only control reads as zero percent
    wire logic [15:0] cool_eff = i_heatcool ? i_cool_mv : 16'h0000;
    wire logic [15:0] tr_val =
        (i_fn == OFA_FN_TR_COOL) ? cool_eff :
        (i_fn == OFA_FN_TR_HEAT) ? i_heat_mv :
        (i_fn == OFA_FN_TR_PV) ? i_pv :
        (i_fn == OFA_FN_TR_RSP) ? i_ramp_sp : i_sp;
    always_comb begin
        o_on = 1'b0;
        o_val = 16'h0000;
        if (i_fn == OFA_FN_HEAT) begin
            o_val = i_heat_mv;
            o_on = |i_heat_mv;
        end else if (i_fn == OFA_FN_COOL) begin
            o_val = cool_eff;
            o_on = |cool_eff;
        end else if (is_bitfn && bit_ok) begin
            o_on = bit_val;
            o_val = bit_val ? 16'hFFFF : 16'h0000;
        end else if (is_tr && i_allow_tr) begin
            o_val = tr_val;
            o_on = |tr_val;
        end
    end
endmodule
`default_nettype wire

// ---- ofa_load_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module ofa_load_model
    import ofa_pkg::*;
(
    // clock
    input wire logic i_mclk,
    // drive from the block
    input wire logic [1:0] i_ctrl_on,
    input wire logic [3:0] i_aux_on,
    input wire logic [15:0] i_ctrl1_val,
    // load state
    output logic [5:0] o_contacts,
    output logic [15:0] o_linear
);
    // coils and current loops follow the drive a clock late; nothing is fed back,
    // so a relay chatter on the block side shows here as a one-cycle contact blip
    always_ff @(posedge i_mclk) begin
        o_contacts <= {i_aux_on, i_ctrl_on};
        o_linear <= i_ctrl1_val;
    end
endmodule
`default_nettype wire

// ---- test_output_function_assignment.sv ----
`timescale 1ns/1ns
`default_nettype none
module test_output_function_assignment;
    import ofa_pkg::*;
    logic i_mclk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    logic [7:0] i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h00000000;
    logic [9:0] src = 10'h000;
    logic [7:0] work = 8'h00;
    logic [15:0] vals [5];
    logic [31:0] o_prdata;
    logic o_pready;
    logic o_pslverr;
    logic [1:0] o_ctrl_on;
    logic [15:0] o_ctrl1_val;
    logic [15:0] o_ctrl2_val;
    logic [3:0] o_aux_on;
    logic o_irq;
    logic [5:0] contacts;
    logic [15:0] linear;
    logic [9:0] cfg;
    logic [7:0] mask;
    logic [4:0] fn [6];
    logic [4:0] f2;
    logic [31:0] r;
    logic [31:0] rd;
    logic err;
    logic irq_a;
    logic [4:0] cfn [4] = '{5'h02, 5'h0D, 5'h0C, 5'h0F};
    logic [31:0] rst_exp [8] = '{32'h1, 32'h0, 32'h3, 32'h4, 32'h5, 32'h6, 32'h31, 32'h3F0};
    logic [9:0] vcfg [5] = '{10'h3B1, 10'h1B1, 10'h331, 10'h031, 10'h3B0};
    logic [31:0] vexp [5] = '{32'h8, 32'h2, 32'h2, 32'h0, 32'h0};
    int n_errors = 0;
    int checks = 0;
    int cyc = 0;
    int seed = 31;

    ofa_core u_ofa_core (
        .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr), .i_alarm_one(src[0]),
        .i_alarm_two(src[1]), .i_alarm_three(src[2]), .i_alarm_four(src[3]),
        .i_heater_break_alarm(src[4]), .i_heater_short_alarm(src[5]),
        .i_input_error(src[6]), .i_remote_setpoint_error(src[7]), .i_program_end(src[8]),
        .i_run(src[9]), .i_work_bits(work), .i_heat_mv(vals[1]), .i_cool_mv(vals[0]),
        .i_pv(vals[2]), .i_ramp_sp(vals[3]), .i_sp(vals[4]), .o_ctrl_on(o_ctrl_on),
        .o_ctrl1_val(o_ctrl1_val), .o_ctrl2_val(o_ctrl2_val), .o_aux_on(o_aux_on),
        .o_irq(o_irq)
    );

    ofa_load_model u_ofa_load_model (
        .i_mclk(i_mclk), .i_ctrl_on(o_ctrl_on), .i_aux_on(o_aux_on),
        .i_ctrl1_val(o_ctrl1_val), .o_contacts(contacts), .o_linear(linear)
    );

    always #25 i_mclk = ~i_mclk;

    // cut a hang short well past the roughly 1400 cycles the run needs
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic report(input logic bad, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (bad) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        report(got !== exp, got, exp);
    endtask

    task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
        report(got !== exp, 32'(got), 32'(exp));
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        report(got !== exp, 32'(got), 32'(exp));
    endtask

    // the slave answers when it likes; only the global cycle ceiling ends the wait
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_mclk);
        i_penable <= 1'b1;
        do @(posedge i_mclk); while (o_pready !== 1'b1);
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask

    task automatic settle();
        repeat (2) @(posedge i_mclk);
        @(negedge i_mclk);
    endtask

    // value an output should carry for a function code; bit functions give all ones when active on a relay output
    function automatic logic [15:0] exp_val(input logic [4:0] f, input logic relay);
        logic b;
        b = 1'b0;
        if (f >= 5'h18 && f <= 5'h1B) return vals[f - 5'h17];
        if (f == 5'h01) return vals[1];
        // cooling, as control or transfer, reads zero under heating-only control
        if (f == 5'h02 || f == 5'h17) return cfg[0] ? vals[0] : 16'h0000;
        case (f)
            5'h03, 5'h04, 5'h05, 5'h06: b = src[f - 5'h03];
            5'h07: b = src[4] | src[5];
            5'h08: b = src[4];
            5'h09: b = src[5];
            5'h0A: b = src[6];
            5'h0B: b = src[7];
            5'h0C: b = cfg[1] & src[8];
            5'h0D: b = src[9];
            5'h0E: b = |(mask & src[7:0]);
            default: b = 1'b0;
        endcase
        if (f >= 5'h0F && f <= 5'h16) b = cfg[2] & work[f - 5'h0F];
        return {16{b & relay}};
    endfunction

    initial begin
        foreach (vals[k]) vals[k] = 16'h0000;
        repeat (20) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        for (int k = 0; k < 8; k++) begin
            apb(1'b0, 8'(4 * k), 32'h00000000);
            cmp_reg(rd, rst_exp[k]);
        end
        cmp_reg({26'h0000000, o_aux_on, o_ctrl_on}, 32'h00000000);
        for (int it = 0; it < 40; it++) begin
            r = $random(seed);
            cfg = 10'h3C0 | (r[9:0] & 10'h037);
            mask = r[23:16];
            fn[0] = r[28:24] % 5'h1C;
            r = $random(seed);
            fn[1] = r[4:0] % 5'h1C;
            for (int k = 2; k < 6; k++) fn[k] = r[5 * k +: 5];
            apb(1'b1, OFA_REG_CFG, 32'(cfg));
            apb(1'b1, OFA_REG_MASK_SUM, 32'(mask));
            for (int k = 0; k < 6; k++) apb(1'b1, 8'(4 * k), 32'(fn[k]));
            r = $random(seed);
            src <= r[9:0];
            work <= r[17:10];
            for (int k = 0; k < 5; k++) vals[k] <= r[20 + k] ? r[31:16] + 16'(k) : 16'h0000;
            settle();
            for (int k = 0; k < 4; k++) begin
                cmp_bit(o_aux_on[k], fn[k + 2] > 5'h16 ? 1'b0 : |exp_val(fn[k + 2], 1'b1));
            end
            cmp_val(o_ctrl1_val, exp_val(fn[0], cfg[4]));
            cmp_bit(o_ctrl_on[0], |exp_val(fn[0], cfg[4]));
            f2 = cfg[0] ? 5'h02 : fn[1];
            cmp_val(o_ctrl2_val, exp_val(f2, cfg[5]));
            cmp_bit(o_ctrl_on[1], |exp_val(f2, cfg[5]));
            cmp_reg(32'({contacts, linear}), 32'({o_aux_on, o_ctrl_on, o_ctrl1_val}));
            apb(1'b0, OFA_REG_CTRL2, 32'h00000000);
            cmp_reg(rd & 32'h1F, 32'(f2));
        end
        apb(1'b1, OFA_REG_MASK_SUM, 32'h000001FF);
        apb(1'b0, OFA_REG_MASK_SUM, 32'h00000000);
        cmp_reg(rd, 32'h000000FF);
        for (int k = 2; k < 6; k++) apb(1'b1, 8'(4 * k), 32'h00000000);
        vals[0] <= 16'h0123;
        for (int k = 0; k < 5; k++) begin
            apb(1'b1, OFA_REG_CFG, 32'(vcfg[k]));
            settle();
            cmp_reg({28'h0000000, o_aux_on}, vexp[k]);
        end
        // heating-only, programs and logic off, linear then relay control output one
        src <= 10'h3FF;
        work <= 8'hFF;
        for (int p = 0; p < 2; p++) begin
            cfg = p ? 10'h3F0 : 10'h3E0;
            apb(1'b1, OFA_REG_CFG, 32'(cfg));
            foreach (cfn[k]) begin
                apb(1'b1, OFA_REG_CTRL1, 32'(cfn[k]));
                settle();
                cmp_val(o_ctrl1_val, exp_val(cfn[k], cfg[4]));
                cmp_bit(o_ctrl_on[0], |exp_val(cfn[k], cfg[4]));
            end
        end
        src <= 10'h000;
        settle();
        apb(1'b1, OFA_REG_IRQ_STAT, 32'h0000003F);
        apb(1'b1, OFA_REG_IRQ_MASK, 32'h00000000);
        src <= 10'h001;
        settle();
        apb(1'b0, OFA_REG_IRQ_STAT, 32'h00000000);
        cmp_reg(rd & 32'h2, 32'h00000002);
        irq_a = o_irq;
        apb(1'b1, OFA_REG_IRQ_MASK, 32'h0000003F);
        settle();
        cmp_bit(irq_a, 1'b0);
        cmp_bit(o_irq, 1'b1);
        apb(1'b1, OFA_REG_IRQ_STAT, 32'h0000003F);
        apb(1'b0, OFA_REG_IRQ_STAT, 32'h00000000);
        cmp_reg(rd, 32'h00000000);
        settle();
        cmp_bit(o_irq, 1'b0);
        apb(1'b1, 8'h2C, 32'hFFFFFFFF);
        cmp_bit(err, 1'b1);
        apb(1'b0, 8'h2C, 32'h00000000);
        cmp_reg({rd[31:1], err}, 32'h00000001);
        apb(1'b1, 8'h48, 32'h0000000D);
        apb(1'b0, OFA_REG_AUX1, 32'h00000000);
        cmp_reg(rd, 32'h00000000);
        wrap_up();
    end
endmodule
`default_nettype wire
